// File: src/plrb_defs.vh
`ifndef PLRB_DEFS_VH
`define PLRB_DEFS_VH
// register byte addresses on the avalon slave
`define PLRB_ADDR_DBG      20'h5D12C
`define PLRB_ADDR_MCTL     20'h5D200
`define PLRB_ADDR_MSTS     20'h5D204
`define PLRB_ADDR_ACTL     20'h5D208
`define PLRB_ADDR_ASTS     20'h5D20C
`define PLRB_ADDR_WDCTL    20'h5D210
`define PLRB_ADDR_WDKEY    20'h5D214
`define PLRB_ADDR_IRQSTS   20'h5D218
`define PLRB_ADDR_IRQMSK   20'h5D21C
// control fields
`define PLRB_BIT_PWR       0
`define PLRB_BIT_SEL       1
`define PLRB_BIT_WDEN      0
`define PLRB_BIT_WDRST     1
// status fields
`define PLRB_BIT_LOCK      0
`define PLRB_BIT_SLIP      1
`define PLRB_BIT_BYPBUSY   2
`define PLRB_BIT_RUN       3
// interrupt bits
`define PLRB_IRQ_MSLIP     0
`define PLRB_IRQ_ASLIP     1
`define PLRB_IRQ_MBYP      2
`define PLRB_IRQ_ABYP      3
`define PLRB_IRQ_W         4
// timing
`define PLRB_BYP_CYC       120
`define PLRB_WD_DEF        16'h4000
`define PLRB_WDKEY_VAL     32'h0000_00A5
`define PLRB_RST_PULSE     8'h10
`define PLRB_RUN_WIN       8'h40
`endif

// File: src/plrb_top.v
// Function
// [R01] watchdog counts on an independent clock, never on the synth output
// [R02] software arms watchdog with reset before selecting the synth clock
// [R03] watchdog expiry resets whole device so start-up runs again
// [R04] scratch bit 0 at 0x0005D12C, kept across watchdog reset
// [R05] software checks main slip right after select, relocks while slipped
// [R06] software checks aux slip after select, relocks until no slip
// [R07] software confirms aux synth runs with timer 2 before usb use
// [R08] bypass or power-down settles within 120 system clock cycles
// [R09] software must not lower dividers during bypass settling
// [R10] software waits 120 cycles after clearing select and power enable
// [R11] usb boot does no retries; system must supply retry mechanism
// [R12] lock flag may be set while synth gives no clock
// [R13] software runs at least five lock sequences on first configuration
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "plrb_defs.vh"
module plrb_top #(
  parameter WD_W     = 16,
  parameter BYP_CYC  = `PLRB_BYP_CYC
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // avalon-mm slave
  input  wire [19:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output wire        avs_response_err_o,
  // main synth
  input  wire        main_lock_i,
  input  wire        main_slip_i,
  input  wire        main_alive_i,
  output wire        main_pwr_o,
  output wire        main_sel_o,
  output wire        main_bypassed_o,
  // auxiliary synth
  input  wire        aux_lock_i,
  input  wire        aux_slip_i,
  input  wire        aux_alive_i,
  output wire        aux_pwr_o,
  output wire        aux_sel_o,
  output wire        aux_bypassed_o,
  // watchdog tick from independent oscillator domain, and device reset out
  input  wire        wd_tick_i,
  output wire        dev_rst_o,
  // interrupt
  output wire        irq_o
);
  // synchronisers: 3 stages, change taken when stages 2 and 3 agree
  // stage 1 may be metastable, so nothing but stage 2 reads it
  wire [6:0] raw_in = {wd_tick_i, aux_alive_i, aux_slip_i, aux_lock_i,
                       main_alive_i, main_slip_i, main_lock_i};
  reg  [6:0] s1_ff, s2_ff, s3_ff, in_ff;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_ff <= 7'h00;
      s2_ff <= 7'h00;
      s3_ff <= 7'h00;
      in_ff <= 7'h00;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      in_ff <= (s2_ff & s3_ff) | (in_ff & (s2_ff | s3_ff));
    end
  end
  // [R12] lock alone is not trusted; run status comes from an activity input
  reg        tick_d_ff;
  wire       tick_rise = in_ff[6] & ~tick_d_ff;

  // bus
  // every access answers in its second cycle, so the master never waits longer
  wire       acc    = avs_read_i | avs_write_i;
  reg        ack_ff;
  reg [31:0] rdata_ff;
  reg        err_ff;
  wire       wr_go  = avs_write_i & ~ack_ff;
  wire       rd_go  = avs_read_i & ~ack_ff;

  reg [31:0] dbg_ff;
  reg [1:0]  mctl_ff, actl_ff;
  reg [1:0]  wdctl_ff;
  reg [WD_W-1:0] wd_cnt_ff;
  reg [4:0]  irq_sts_ff, irq_msk_ff;
  reg        irq_ff;
  reg [7:0]  rst_cnt_ff;
  reg        dev_rst_ff;

  function known_addr;
    input [19:0] a;
    begin
      case (a)
        `PLRB_ADDR_DBG, `PLRB_ADDR_MCTL, `PLRB_ADDR_MSTS, `PLRB_ADDR_ACTL,
        `PLRB_ADDR_ASTS, `PLRB_ADDR_WDCTL, `PLRB_ADDR_WDKEY,
        `PLRB_ADDR_IRQSTS, `PLRB_ADDR_IRQMSK: known_addr = 1'b1;
        default: known_addr = 1'b0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    begin
      merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
               be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // write strobes; control registers need the low byte lane
  wire wr_hit_mctl  = wr_go & (avs_address_i == `PLRB_ADDR_MCTL) & avs_byteenable_i[0];
  wire wr_hit_actl  = wr_go & (avs_address_i == `PLRB_ADDR_ACTL) & avs_byteenable_i[0];
  wire wr_hit_wdctl = wr_go & (avs_address_i == `PLRB_ADDR_WDCTL) & avs_byteenable_i[0];
  wire wr_hit_irqs  = wr_go & (avs_address_i == `PLRB_ADDR_IRQSTS) & avs_byteenable_i[0];
  wire wr_hit_irqm  = wr_go & (avs_address_i == `PLRB_ADDR_IRQMSK) & avs_byteenable_i[0];
  wire wr_hit_dbg   = wr_go & (avs_address_i == `PLRB_ADDR_DBG);

  // bypass settle counters per synth, generated
  // loaded one short: bypassed_o sits one register behind busy and must land in the window
  localparam [31:0] BYP_LOAD = BYP_CYC - 1;
  wire [1:0] busy_w;
  wire [1:0] byp_start;
  wire [1:0] byp_done;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_byp
      reg [7:0]  cnt_ff;
      reg        busy_ff;
      wire [1:0] cur = g ? actl_ff : mctl_ff;
      wire       hit = g ? wr_hit_actl : wr_hit_mctl;
      // a clear of power or select starts the settle window
      assign byp_start[g] = hit & ((cur[`PLRB_BIT_PWR] & ~avs_writedata_i[`PLRB_BIT_PWR]) |
                                   (cur[`PLRB_BIT_SEL] & ~avs_writedata_i[`PLRB_BIT_SEL]));
      assign byp_done[g]  = busy_ff & (cnt_ff == 8'h01);
      assign busy_w[g]    = busy_ff;
      always @(posedge clk_i) begin
        if (!rstn_i) begin
          cnt_ff  <= 8'h00;
          busy_ff <= 1'b0;
        end else if (byp_start[g]) begin
          cnt_ff  <= BYP_LOAD[7:0]; // R08
          busy_ff <= 1'b1;
        end else if (busy_ff) begin
          cnt_ff  <= cnt_ff - 8'h01;
          busy_ff <= ~byp_done[g]; // R08
        end
      end
    end
  endgenerate

  // outputs to synth; select/power follow the register at once, bypassed shows a cleared select only after settle completes
  reg main_byp_ff, aux_byp_ff;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      main_byp_ff <= 1'b1;
      aux_byp_ff  <= 1'b1;
    end else begin
      main_byp_ff <= ~mctl_ff[`PLRB_BIT_SEL] & ~busy_w[0]; // R08
      aux_byp_ff  <= ~actl_ff[`PLRB_BIT_SEL] & ~busy_w[1]; // R08
    end
  end

  // slip edges, settle completions and watchdog expiry for interrupts
  reg        mslip_d_ff, aslip_d_ff;
  wire       wd_expire;
  wire [4:0] ev_all = {wd_expire, byp_done[1], byp_done[0],
                       in_ff[4] & ~aslip_d_ff, in_ff[1] & ~mslip_d_ff};

  // watchdog: counts ticks of the free-running oscillator, not the synth
  wire wd_kick = wr_go & (avs_address_i == `PLRB_ADDR_WDKEY) &
                 (avs_writedata_i == `PLRB_WDKEY_VAL);
  assign wd_expire = wdctl_ff[`PLRB_BIT_WDEN] & tick_rise & (wd_cnt_ff == {WD_W{1'b0}});

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wd_cnt_ff <= `PLRB_WD_DEF;
      tick_d_ff <= 1'b0;
    end else begin
      tick_d_ff <= in_ff[6];
      // a disabled watchdog holds its reload, so enabling starts a full span
      if (wd_kick | ~wdctl_ff[`PLRB_BIT_WDEN])
        wd_cnt_ff <= `PLRB_WD_DEF;
      else if (tick_rise & (wd_cnt_ff != {WD_W{1'b0}}))
        wd_cnt_ff <= wd_cnt_ff - {{(WD_W-1){1'b0}}, 1'b1}; // R01
    end
  end

  wire        main_alive_w = in_ff[2];
  wire [31:0] mst = {28'h0000000, main_alive_w, busy_w[0], in_ff[1], in_ff[0]};
  wire [31:0] ast = {28'h0000000, in_ff[5], busy_w[1], in_ff[4], in_ff[3]};

  // read mux; unmapped addresses read zero
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_i)
      `PLRB_ADDR_DBG:    nxt_rdata = dbg_ff;
      `PLRB_ADDR_MCTL:   nxt_rdata = {30'h00000000, mctl_ff};
      `PLRB_ADDR_MSTS:   nxt_rdata = mst; // R05
      `PLRB_ADDR_ACTL:   nxt_rdata = {30'h00000000, actl_ff};
      `PLRB_ADDR_ASTS:   nxt_rdata = ast; // R06
      `PLRB_ADDR_WDCTL:  nxt_rdata = {30'h00000000, wdctl_ff};
      `PLRB_ADDR_WDKEY:  nxt_rdata = {{(32-WD_W){1'b0}}, wd_cnt_ff};
      `PLRB_ADDR_IRQSTS: nxt_rdata = {27'h0000000, irq_sts_ff};
      `PLRB_ADDR_IRQMSK: nxt_rdata = {27'h0000000, irq_msk_ff};
      default:           nxt_rdata = 32'h0000_0000;
    endcase
  end

  // set wins over write-one-to-clear, so an event in the clear cycle is kept
  reg [4:0] nxt_irq_sts;
  always @* begin
    nxt_irq_sts = irq_sts_ff | ev_all;
    if (wr_hit_irqs)
      nxt_irq_sts = (irq_sts_ff & ~avs_writedata_i[4:0]) | ev_all;
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_ff     <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      err_ff     <= 1'b0;
      mctl_ff    <= 2'h0;
      actl_ff    <= 2'h0;
      wdctl_ff   <= 2'h0;
      irq_sts_ff <= 5'h00;
      irq_msk_ff <= 5'h00;
      irq_ff     <= 1'b0;
      mslip_d_ff <= 1'b0;
      aslip_d_ff <= 1'b0;
    end else begin
      mslip_d_ff <= in_ff[1];
      aslip_d_ff <= in_ff[4];
      ack_ff     <= acc & ~ack_ff;
      if (acc & ~ack_ff) begin
        err_ff <= ~known_addr(avs_address_i);
      end
      if (rd_go) begin
        rdata_ff <= nxt_rdata;
      end
      if (wr_hit_mctl)
        mctl_ff <= avs_writedata_i[1:0];
      if (wr_hit_actl)
        actl_ff <= avs_writedata_i[1:0];
      if (wr_hit_wdctl)
        wdctl_ff <= avs_writedata_i[1:0];
      if (wr_hit_irqm)
        irq_msk_ff <= avs_writedata_i[4:0];
      irq_sts_ff <= nxt_irq_sts;
      irq_ff     <= |(irq_sts_ff & irq_msk_ff);
    end
  end

  // device reset pulse on expiry; state here survives it
  // boot code that does no retry of its own still gets a fresh start here
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      rst_cnt_ff <= 8'h00;
      dev_rst_ff <= 1'b0;
    end else if (wd_expire & wdctl_ff[`PLRB_BIT_WDRST]) begin
      rst_cnt_ff <= `PLRB_RST_PULSE; // R03 R11
      dev_rst_ff <= 1'b1;
    end else if (rst_cnt_ff != 8'h00) begin
      rst_cnt_ff <= rst_cnt_ff - 8'h01;
      dev_rst_ff <= (rst_cnt_ff != 8'h01);
    end
  end

  // scratch lives only on the power-on reset, so it tells a retry reset apart
  always @(posedge clk_i) begin
    if (!rstn_i)
      dbg_ff <= 32'h0000_0000;
    else if (wr_hit_dbg)
      dbg_ff <= merge(dbg_ff, avs_writedata_i, avs_byteenable_i); // R04
  end

  assign avs_readdata_o     = rdata_ff;
  assign avs_waitrequest_o  = acc & ~ack_ff;
  assign avs_response_err_o = err_ff;
  assign main_pwr_o         = mctl_ff[`PLRB_BIT_PWR];
  assign main_sel_o         = mctl_ff[`PLRB_BIT_SEL];
  assign aux_pwr_o          = actl_ff[`PLRB_BIT_PWR];
  assign aux_sel_o          = actl_ff[`PLRB_BIT_SEL];
  assign main_bypassed_o    = main_byp_ff;
  assign aux_bypassed_o     = aux_byp_ff;
  assign dev_rst_o          = dev_rst_ff; // R03
  assign irq_o              = irq_ff;
endmodule
`default_nettype wire

// File: testbench/plrb_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrb_defs.vh"
module plrb_top_properties (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [19:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        avs_response_err_o,
  input wire logic        main_pwr_o,
  input wire logic        main_sel_o,
  input wire logic        main_bypassed_o,
  input wire logic        aux_sel_o,
  input wire logic        aux_bypassed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("no wait state on new request");
  property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("answer late");
  property p_err; avs_read_i && avs_waitrequest_o && avs_address_i[19:12] != 8'h5D
    |=> avs_response_err_o && avs_readdata_o == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  property p_ok; avs_read_i && avs_waitrequest_o && avs_address_i == `PLRB_ADDR_DBG
    |=> !avs_response_err_o; endproperty
  a_ok: assert property (p_ok) else $error("scratch read refused");
  property p_pwr; avs_write_i && avs_waitrequest_o && avs_address_i == `PLRB_ADDR_MCTL
    |=> {main_sel_o, main_pwr_o} == $past(avs_writedata_i[1:0]); endproperty
  a_pwr: assert property (p_pwr) else $error("main control bits not written");
  // settling is never instant, and bypassed must rise within 128 cycles of the sampled fall
  property p_mbyp; $fell(main_sel_o) |=> !main_bypassed_o[*8] ##[1:120] main_bypassed_o; endproperty
  a_mbyp: assert property (p_mbyp) else $error("main bypass timing");
  property p_abyp; $fell(aux_sel_o) |=> !aux_bypassed_o[*8] ##[1:120] aux_bypassed_o; endproperty
  a_abyp: assert property (p_abyp) else $error("aux bypass timing");
  property p_rd; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_rd: assert property (p_rd) else $error("read data moved without read");
endmodule
bind plrb_top plrb_top_properties plrb_top_properties_i (.*);
`default_nettype wire

// File: testbench/plrb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrb_defs.vh"
`define CHK(nm, ex, se) begin n_tests++; if ((se) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, se); end end
module plrb_top_tb;
  typedef struct {logic [19:0] a; logic [31:0] d; logic [31:0] x; logic e;} plrb_row_t;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [19:0] adr = 20'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        lock = 1'b0;
  logic        slip = 1'b0;
  logic        alive = 1'b0;
  wire         mpwr, apwr;
  logic        tk_en = 1'b0;
  logic [1:0]  tk = 2'h0;
  logic [31:0] q;
  logic        e;
  wire  [31:0] rdata;
  wire         wreq, err, msel, mbyp, asel, abyp, drst, irq;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n;
  plrb_row_t   rows [4] = '{'{`PLRB_ADDR_DBG, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
    '{`PLRB_ADDR_IRQMSK, 32'hFFFF_FFFF, 32'h0000_001F, 1'b0},
    '{20'h00100, 32'h1234_5678, 32'h0, 1'b1}, '{`PLRB_ADDR_MCTL, 32'h1, 32'h1, 1'b0}};
  always #25 clk_i = ~clk_i;
  // ticks come slow enough for the synchroniser to see each one
  always @(posedge clk_i) if (tk_en) tk <= tk + 2'h1;
  plrb_top plrb_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wdat),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_err_o(err),
    .main_lock_i(lock), .main_slip_i(slip), .main_alive_i(alive), .main_pwr_o(mpwr),
    .main_sel_o(msel), .main_bypassed_o(mbyp), .aux_lock_i(lock), .aux_slip_i(slip),
    .aux_alive_i(alive), .aux_pwr_o(apwr), .aux_sel_o(asel), .aux_bypassed_o(abyp),
    .wd_tick_i(tk[1]), .dev_rst_o(drst), .irq_o(irq));
  task bus(input logic we, input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    rd <= !we;
    wr <= we;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    e = err;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) n_mismatch++;
  endtask
  task end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, `PLRB_ADDR_DBG, 32'h0);
    `CHK("dbg reset", 32'h0, q)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      `CHK("readback", rows[i].x, q)
      `CHK("response", rows[i].e, e)
    end
    lock <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(1'b0, `PLRB_ADDR_MSTS, 32'h0);
    `CHK("lock without clock", 2'b01, {q[`PLRB_BIT_RUN], q[`PLRB_BIT_LOCK]})
    alive <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(1'b0, `PLRB_ADDR_ASTS, 32'h0);
    `CHK("aux running", 1'b1, q[`PLRB_BIT_RUN])
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, `PLRB_ADDR_MCTL, 32'h0);
      bus(1'b1, `PLRB_ADDR_MCTL, 32'h1);
      bus(1'b0, `PLRB_ADDR_MSTS, 32'h0);
      `CHK("lock sequence", 1'b1, q[`PLRB_BIT_LOCK])
    end
    repeat (130) @(posedge clk_i);
    bus(1'b1, `PLRB_ADDR_IRQSTS, 32'h0000_001F);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, i ? `PLRB_ADDR_ACTL : `PLRB_ADDR_MCTL, 32'h3);
      `CHK("select", 1'b1, i ? asel : msel)
      `CHK("power", 1'b1, i ? apwr : mpwr)
      bus(1'b1, i ? `PLRB_ADDR_ACTL : `PLRB_ADDR_MCTL, 32'h1);
      bus(1'b0, i ? `PLRB_ADDR_ASTS : `PLRB_ADDR_MSTS, 32'h0);
      `CHK("settle busy", 1'b1, q[`PLRB_BIT_BYPBUSY])
      n = 0;
      while ((i ? abyp : mbyp) !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
      `CHK("settle span", 1'b1, n > 100 && n <= 120)
      repeat (3) @(posedge clk_i);
      `CHK("settle irq", 1'b1, irq)
      bus(1'b1, `PLRB_ADDR_IRQSTS, 32'h0000_000C);
      repeat (3) @(posedge clk_i);
      `CHK("irq cleared", 1'b0, irq)
    end
    bus(1'b1, `PLRB_ADDR_IRQMSK, 32'h0);
    slip <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK("masked irq", 1'b0, irq)
    bus(1'b0, `PLRB_ADDR_IRQSTS, 32'h0);
    `CHK("slip status", 2'b11, q[1:0])
    bus(1'b1, `PLRB_ADDR_IRQMSK, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK("unmasked irq", 1'b1, irq)
    slip <= 1'b0;
    bus(1'b1, `PLRB_ADDR_IRQSTS, 32'h3);
    repeat (3) @(posedge clk_i);
    `CHK("slip cleared", 1'b0, irq)
    bus(1'b1, `PLRB_ADDR_DBG, 32'h1);
    bus(1'b1, `PLRB_ADDR_WDCTL, 32'h3);
    tk_en <= 1'b1;
    n = 0;
    while (drst !== 1'b1 && n < 70000) begin @(posedge clk_i); n++; end
    `CHK("watchdog reset", 1'b1, drst)
    tk_en <= 1'b0;
    repeat (40) @(posedge clk_i);
    bus(1'b0, `PLRB_ADDR_DBG, 32'h0);
    `CHK("dbg kept", 32'h1, q)
    end_of_test;
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
